// ===== rtl/ctx_top.sv
// Purpose: continuous transmission test mode control, registers and byte streamer
// Assumes: register port strobes are one cycle, never both at once
// Notes:   the analog front end consumes the tx carrier; pll lock comes in as a level
`timescale 1ns/1ps
module ctx_top (
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                RESET,
  // register port
  input  wire ctx_pkg::ctx_bus_type REG_BUS,
  output logic [7:0]               REG_RDATA,
  // synthesizer
  input  wire logic                PLL_LOCKED,
  output logic                     PLL_ENABLE,
  // transmit stream to front end
  output ctx_pkg::ctx_tx_type      TX_OUT,
  output logic [7:0]               CHANNEL,
  output logic [7:0]               OUT_POWER,
  // interrupt
  output logic                     IRQ
);

  // address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire logic       wr           = REG_BUS.wr;
  wire logic       rd           = REG_BUS.rd;
  wire logic [7:0] addr         = REG_BUS.addr;
  wire logic [7:0] wdata        = REG_BUS.wdata;
  wire logic       wr_test_ctrl = wr && hit(addr, ctx_pkg::ADR_TEST_CTRL);
  wire logic       wr_device_id = wr && hit(addr, ctx_pkg::ADR_DEVICE_ID);
  wire logic       wr_state_cmd = wr && hit(addr, ctx_pkg::ADR_STATE_CMD);
  wire logic       wr_ctl1      = wr && hit(addr, ctx_pkg::ADR_RADIO_CTL1);
  wire logic       wr_ctl2      = wr && hit(addr, ctx_pkg::ADR_RADIO_CTL2);
  wire logic       wr_chan      = wr && hit(addr, ctx_pkg::ADR_CHAN_SEL);
  wire logic       wr_power     = wr && hit(addr, ctx_pkg::ADR_OUT_POWER);
  wire logic       wr_rxctl     = wr && hit(addr, ctx_pkg::ADR_RX_CTL);
  wire logic       wr_irq_clr   = wr && hit(addr, ctx_pkg::ADR_IRQ_CLEAR);
  wire logic       wr_irq_en    = wr && hit(addr, ctx_pkg::ADR_IRQ_ENABLE);
  wire logic       wr_fb_index  = wr && hit(addr, ctx_pkg::ADR_FB_INDEX);
  wire logic       wr_fb_data   = wr && hit(addr, ctx_pkg::ADR_FB_DATA);

  // registers
  logic [7:0]                  test_ctrl_q;
  logic [7:0]                  ctl1_q;
  logic [7:0]                  ctl2_q;
  logic [7:0]                  chan_q;
  logic [7:0]                  power_q;
  logic [7:0]                  rxctl_q;
  logic [ctx_pkg::IRQ_W-1:0]   irq_stat_q;
  logic [ctx_pkg::IRQ_W-1:0]   irq_stat_d;
  logic [ctx_pkg::IRQ_W-1:0]   irq_en_q;
  logic [ctx_pkg::FB_AW-1:0]   fb_wptr_q;
  logic [7:0]                  fb_q [ctx_pkg::FB_DEPTH];
  logic [7:0]                  rdata_q;
  logic [7:0]                  rdata_d;
  logic                        irq_q;
  logic                        pll_en_q;
  logic                        lock_seen_q;
  ctx_pkg::ctx_radio_type      radio_q;
  ctx_pkg::ctx_radio_type      radio_d;
  ctx_pkg::ctx_tx_type         tx_q;
  ctx_pkg::ctx_tx_type         tx_d;
  logic [ctx_pkg::FB_AW-1:0]   rptr_q;
  logic [ctx_pkg::FB_AW-1:0]   rptr_d;
  logic [ctx_pkg::BYTE_CNT_W-1:0] bcnt_q;
  logic [ctx_pkg::BYTE_CNT_W-1:0] bcnt_d;
  logic                        armed;

  ctx_unlock u_unlock (
    .clk          (CLK_SYS),
    .reset        (RESET),
    .wr_test_ctrl (wr_test_ctrl),
    .wr_device_id (wr_device_id),
    .wdata        (wdata),
    .armed        (armed)
  );

  // simple configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      test_ctrl_q <= 8'h00;
      ctl1_q      <= ctx_pkg::CTL1_RESET;
      ctl2_q      <= ctx_pkg::CTL2_RESET;
      chan_q      <= ctx_pkg::CHAN_RESET;
      power_q     <= ctx_pkg::POWER_RESET;
      rxctl_q     <= ctx_pkg::RXCTL_RESET;
      irq_en_q    <= '0;
    end else begin
      if (wr_test_ctrl) test_ctrl_q <= wdata;
      if (wr_ctl1)      ctl1_q      <= wdata;
      if (wr_ctl2)      ctl2_q      <= wdata;
      if (wr_chan)      chan_q      <= wdata;
      if (wr_power)     power_q     <= wdata;
      if (wr_rxctl)     rxctl_q     <= wdata;
      if (wr_irq_en)    irq_en_q    <= wdata[ctx_pkg::IRQ_W-1:0];
    end
  end

  // frame buffer write pointer, auto increments on data writes
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fb_wptr_q <= '0;
    end else if (wr_fb_index) begin
      fb_wptr_q <= wdata[ctx_pkg::FB_AW-1:0];
    end else if (wr_fb_data) begin
      fb_wptr_q <= fb_wptr_q + 1'b1;
    end
  end

  // frame buffer storage, one flop row per entry
  genvar gi;
  generate
    for (gi = 0; gi < ctx_pkg::FB_DEPTH; gi++) begin : g_fb
      wire logic sel = wr_fb_data && (fb_wptr_q == ctx_pkg::FB_AW'(gi));
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          fb_q[gi] <= 8'h00;
        end else if (sel) begin
          fb_q[gi] <= wdata;
        end
      end
    end
  endgenerate

  // frame length and tone mode
  wire logic [ctx_pkg::FB_AW-1:0] frame_len = fb_q[0][ctx_pkg::FB_AW-1:0];
  wire logic tone_mode = (ctl2_q[ctx_pkg::RATE_LSB +: 2] == ctx_pkg::RATE_2M);
  wire logic [ctx_pkg::CMD_W-1:0] cmd = wdata[ctx_pkg::CMD_W-1:0];

  // synthesizer lock edge: input taken as synchronous
  wire logic lock_rise = PLL_LOCKED && !lock_seen_q && pll_en_q;

  // radio state sequencing
  always_comb begin
    radio_d = radio_q;
    case (radio_q)
      ctx_pkg::RS_OFF: begin
        if (wr_state_cmd && cmd == ctx_pkg::CMD_PLL_ON) begin
          radio_d = ctx_pkg::RS_PLL_ON;
        end
      end
      ctx_pkg::RS_PLL_ON: begin
        if (wr_state_cmd && cmd == ctx_pkg::CMD_RADIO_OFF) begin
          radio_d = ctx_pkg::RS_OFF;
        end else if (wr_state_cmd && cmd == ctx_pkg::CMD_TX_START && armed && lock_seen_q) begin
          radio_d = ctx_pkg::RS_BUSY_TX;
        end
      end
      ctx_pkg::RS_BUSY_TX: begin
        // only leaving the test mode ends the stream
        if (!armed) begin
          radio_d = ctx_pkg::RS_OFF;
        end
      end
      default: radio_d = ctx_pkg::RS_OFF;
    endcase
  end

  wire logic tx_start = (radio_q == ctx_pkg::RS_PLL_ON) && (radio_d == ctx_pkg::RS_BUSY_TX);
  wire logic sending  = (radio_q == ctx_pkg::RS_BUSY_TX);
  wire logic byte_due = sending && (bcnt_q == '0);
  wire logic last_byte = (rptr_q >= frame_len);
  wire logic frame_wrap = byte_due && last_byte;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      radio_q     <= ctx_pkg::RS_OFF;
      pll_en_q    <= 1'b0;
      lock_seen_q <= 1'b0;
    end else begin
      radio_q     <= radio_d;
      pll_en_q    <= (radio_d != ctx_pkg::RS_OFF);
      lock_seen_q <= pll_en_q && PLL_LOCKED;
    end
  end

  // byte streamer: psdu only, index 1 up to length, then wrap
  always_comb begin
    rptr_d = rptr_q;
    bcnt_d = bcnt_q;
    if (!sending) begin
      rptr_d = 7'h01;
      bcnt_d = '0;
    end else if (byte_due) begin
      bcnt_d = ctx_pkg::BYTE_CNT_W'(ctx_pkg::BYTE_CYCLES - 1);
      rptr_d = last_byte ? 7'h01 : rptr_q + 1'b1;
    end else begin
      bcnt_d = bcnt_q - 1'b1;
    end
  end

  // per byte: tone for uniform 0x00/0xFF in tone mode, else modulated
  wire logic [7:0] cur_byte = fb_q[rptr_q];
  wire logic       up_tone   = tone_mode && (cur_byte == ctx_pkg::BYTE_ONES);
  wire logic       down_tone = tone_mode && (cur_byte == ctx_pkg::BYTE_ZERO);

  always_comb begin
    tx_d        = tx_q;
    tx_d.active = sending;
    tx_d.strobe = byte_due;
    if (!sending) begin
      tx_d = '0;
    end else if (byte_due) begin
      tx_d.data      = cur_byte;
      tx_d.tone_up   = up_tone;
      tx_d.tone_down = down_tone;
      tx_d.modulated = !(up_tone || down_tone);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rptr_q <= 7'h01;
      bcnt_q <= '0;
      tx_q   <= '0;
    end else begin
      rptr_q <= rptr_d;
      bcnt_q <= bcnt_d;
      tx_q   <= tx_d;
    end
  end

  // sticky interrupt status, set wins over clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_irq_clr) begin
      irq_stat_d = irq_stat_q & ~wdata[ctx_pkg::IRQ_W-1:0];
    end
    if (lock_rise)  irq_stat_d[ctx_pkg::IRQ_PLL_LOCK]   = 1'b1;
    if (tx_start)   irq_stat_d[ctx_pkg::IRQ_TX_START]   = 1'b1;
    if (frame_wrap) irq_stat_d[ctx_pkg::IRQ_FRAME_WRAP] = 1'b1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_en_q);
    end
  end

  // read mux, data stand one cycle after the strobe
  wire logic [7:0] radio_stat =
    (radio_q == ctx_pkg::RS_BUSY_TX) ? ctx_pkg::STAT_BUSY_TX :
    (radio_q == ctx_pkg::RS_PLL_ON)  ? ctx_pkg::STAT_PLL_ON  : ctx_pkg::STAT_RADIO_OFF;

  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        ctx_pkg::ADR_TEST_CTRL:  rdata_d = test_ctrl_q;
        ctx_pkg::ADR_DEVICE_ID:  rdata_d = 8'h00;
        ctx_pkg::ADR_STATE_CMD:  rdata_d = radio_stat;
        ctx_pkg::ADR_RADIO_STAT: rdata_d = radio_stat;
        ctx_pkg::ADR_RADIO_CTL1: rdata_d = ctl1_q;
        ctx_pkg::ADR_RADIO_CTL2: rdata_d = ctl2_q;
        ctx_pkg::ADR_CHAN_SEL:   rdata_d = chan_q;
        ctx_pkg::ADR_OUT_POWER:  rdata_d = power_q;
        ctx_pkg::ADR_RX_CTL:     rdata_d = rxctl_q;
        ctx_pkg::ADR_IRQ_STATUS: rdata_d = {{(8-ctx_pkg::IRQ_W){1'b0}}, irq_stat_q};
        ctx_pkg::ADR_IRQ_ENABLE: rdata_d = {{(8-ctx_pkg::IRQ_W){1'b0}}, irq_en_q};
        ctx_pkg::ADR_FB_INDEX:   rdata_d = {1'b0, fb_wptr_q};
        ctx_pkg::ADR_FB_DATA:    rdata_d = fb_q[fb_wptr_q];
        ctx_pkg::ADR_MODE_STAT:  rdata_d = {5'h00, tone_mode, sending, armed};
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA  = rdata_q;
  assign PLL_ENABLE = pll_en_q;
  assign TX_OUT     = tx_q;
  assign CHANNEL    = chan_q;
  assign OUT_POWER  = power_q;
  assign IRQ        = irq_q;

endmodule

// ===== pkg/ctx_pkg.sv
// Purpose: constants and carrier types for the continuous transmission test block
// Assumes: 8-bit register port, 20 MHz system clock
// Notes:   register offsets are byte indices on the plain register port
package ctx_pkg;

  // register offsets
  localparam logic [7:0] ADR_TEST_CTRL   = 8'h00;
  localparam logic [7:0] ADR_DEVICE_ID   = 8'h01;
  localparam logic [7:0] ADR_STATE_CMD   = 8'h02;
  localparam logic [7:0] ADR_RADIO_STAT  = 8'h03;
  localparam logic [7:0] ADR_RADIO_CTL1  = 8'h04;
  localparam logic [7:0] ADR_RADIO_CTL2  = 8'h05;
  localparam logic [7:0] ADR_CHAN_SEL    = 8'h06;
  localparam logic [7:0] ADR_OUT_POWER   = 8'h07;
  localparam logic [7:0] ADR_RX_CTL      = 8'h08;
  localparam logic [7:0] ADR_IRQ_STATUS  = 8'h09;
  localparam logic [7:0] ADR_IRQ_CLEAR   = 8'h0A;
  localparam logic [7:0] ADR_IRQ_ENABLE  = 8'h0B;
  localparam logic [7:0] ADR_FB_INDEX    = 8'h0C;
  localparam logic [7:0] ADR_FB_DATA     = 8'h0D;
  localparam logic [7:0] ADR_MODE_STAT   = 8'h0E;

  // unlock sequence values
  localparam logic [7:0] UNLOCK_CTRL     = 8'h0F;
  localparam logic [7:0] UNLOCK_ID_A     = 8'h54;
  localparam logic [7:0] UNLOCK_ID_B     = 8'h46;
  localparam logic [7:0] UNLOCK_LEAVE    = 8'h00;

  // state commands and status codes
  localparam logic [4:0] CMD_TX_START    = 5'h02;
  localparam logic [4:0] CMD_RADIO_OFF   = 5'h03;
  localparam logic [4:0] CMD_PLL_ON      = 5'h09;
  localparam logic [7:0] STAT_RADIO_OFF  = 8'h08;
  localparam logic [7:0] STAT_PLL_ON     = 8'h09;
  localparam logic [7:0] STAT_BUSY_TX    = 8'h02;
  localparam int         CMD_W           = 5;

  // field layouts and reset values
  localparam logic [1:0] RATE_2M         = 2'h3;
  localparam int         RATE_LSB        = 0;
  localparam logic [7:0] CTL1_RESET      = 8'h20;
  localparam logic [7:0] CTL2_RESET      = 8'h00;
  localparam logic [7:0] RXCTL_RESET     = 8'h00;
  localparam logic [7:0] CHAN_RESET      = 8'h2B;
  localparam logic [7:0] POWER_RESET     = 8'h00;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] BYTE_ONES       = 8'hFF;

  // interrupt bits
  localparam int         IRQ_W           = 3;
  localparam int         IRQ_PLL_LOCK    = 0;
  localparam int         IRQ_TX_START    = 1;
  localparam int         IRQ_FRAME_WRAP  = 2;

  // frame buffer
  localparam int         FB_DEPTH        = 128;
  localparam int         FB_AW           = 7;

  // byte period on air, at 250 kb/s
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         BYTE_TIME_NS    = 32000;
  localparam int         BYTE_CYCLES     = BYTE_TIME_NS / CLK_PERIOD_NS;
  localparam int         BYTE_CNT_W      = 10;

  typedef enum logic [1:0] {
    RS_OFF,
    RS_PLL_ON,
    RS_BUSY_TX
  } ctx_radio_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctx_bus_type;

  typedef struct packed {
    logic       active;
    logic       strobe;
    logic [7:0] data;
    logic       modulated;
    logic       tone_up;
    logic       tone_down;
  } ctx_tx_type;

endpackage

// ===== rtl/ctx_unlock.sv
// Purpose: unlock sequencer that arms the continuous transmission test mode
// Assumes: write pulses are one cycle long and carry their data
// Notes:   before arming, any other write to the id register drops back to idle
`timescale 1ns/1ps
module ctx_unlock (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // decoded writes
  input  wire logic       wr_test_ctrl,
  input  wire logic       wr_device_id,
  input  wire logic [7:0] wdata,
  // state
  output logic            armed
);

  typedef enum logic [1:0] {
    UL_IDLE,
    UL_CTRL_SEEN,
    UL_FIRST_SEEN,
    UL_ARMED
  } ctx_unlock_type;

  ctx_unlock_type state_q;
  ctx_unlock_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      UL_IDLE: begin
        if (wr_test_ctrl && wdata == ctx_pkg::UNLOCK_CTRL) begin
          state_d = UL_CTRL_SEEN;
        end
      end
      UL_CTRL_SEEN: begin
        if (wr_device_id) begin
          state_d = (wdata == ctx_pkg::UNLOCK_ID_A) ? UL_FIRST_SEEN : UL_IDLE;
        end
      end
      UL_FIRST_SEEN: begin
        if (wr_device_id) begin
          state_d = (wdata == ctx_pkg::UNLOCK_ID_B) ? UL_ARMED : UL_IDLE;
        end
      end
      UL_ARMED: begin
        if (wr_device_id && wdata == ctx_pkg::UNLOCK_LEAVE) begin
          state_d = UL_IDLE;
        end
      end
      default: state_d = UL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= UL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign armed = (state_q == UL_ARMED);

endmodule

// ===== bench/ctx_top_assertions.sv
// Purpose: concurrent checks on the continuous transmission block ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   byte gap counted in helper logic, 640 cycles per byte
`timescale 1ns/1ps
module ctx_top_assertions (
  // clock and reset
  input wire logic                 CLK_SYS,
  input wire logic                 RESET,
  // register port
  input wire ctx_pkg::ctx_bus_type REG_BUS,
  input wire logic [7:0]           REG_RDATA,
  // synthesizer
  input wire logic                 PLL_LOCKED,
  input wire logic                 PLL_ENABLE,
  // transmit stream and levels
  input wire ctx_pkg::ctx_tx_type  TX_OUT,
  input wire logic [7:0]           CHANNEL,
  input wire logic [7:0]           OUT_POWER,
  input wire logic                 IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  wire logic       wr_start = REG_BUS.wr && REG_BUS.addr == ctx_pkg::ADR_STATE_CMD
                              && REG_BUS.wdata[4:0] == ctx_pkg::CMD_TX_START;
  wire logic       wr_leave = REG_BUS.wr && REG_BUS.addr == ctx_pkg::ADR_DEVICE_ID
                              && REG_BUS.wdata == ctx_pkg::UNLOCK_LEAVE;
  logic      [9:0] gap_q;
  logic            seen_q;
  wire logic [9:0] gap_d    = TX_OUT.strobe ? 10'h000 : (gap_q == 10'h3FF ? gap_q : gap_q + 10'h001);

  // cycles since the last byte strobe
  always_ff @(posedge CLK_SYS) begin
    gap_q  <= RESET ? 10'h000 : gap_d;
    seen_q <= RESET ? 1'b0 : (TX_OUT.active ? (seen_q | TX_OUT.strobe) : 1'b0);
  end

  chk_byte_period: assert property (TX_OUT.active && seen_q |-> TX_OUT.strobe == (gap_q == 10'd639))
    else $error("byte strobe spacing wrong");
  chk_tone_onehot: assert property (TX_OUT.active
    |-> $onehot({TX_OUT.modulated, TX_OUT.tone_up, TX_OUT.tone_down}))
    else $error("tone flags not one-hot");
  chk_tone_up_byte: assert property (TX_OUT.active && TX_OUT.tone_up |-> TX_OUT.data == 8'hFF)
    else $error("tone above centre on wrong byte");
  chk_tone_down_byte: assert property (TX_OUT.active && TX_OUT.tone_down |-> TX_OUT.data == 8'h00)
    else $error("tone below centre on wrong byte");
  chk_start_latency: assert property ($rose(TX_OUT.active)
    |-> TX_OUT.strobe && PLL_ENABLE && $past(wr_start, 2))
    else $error("transmit start timing wrong");
  // leave passes unlock state, radio state and tx register: three stages
  chk_active_stays: assert property ($fell(TX_OUT.active) && !$past(RESET) |-> $past(wr_leave, 3))
    else $error("transmission stopped without leave");
  chk_leave_stop: assert property (wr_leave && TX_OUT.active |-> ##3 !TX_OUT.active)
    else $error("transmission not stopped after leave");
  chk_data_hold: assert property (TX_OUT.active && !TX_OUT.strobe && $past(TX_OUT.active)
    |-> $stable(TX_OUT.data))
    else $error("byte changed between strobes");

  cover property ($rose(TX_OUT.active));
  cover property (TX_OUT.strobe && TX_OUT.tone_up);
  cover property (TX_OUT.strobe && TX_OUT.tone_down);
  cover property (TX_OUT.strobe && TX_OUT.modulated);
endmodule

bind ctx_top ctx_top_assertions ctx_top_assertions_i (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .REG_BUS(REG_BUS), .REG_RDATA(REG_RDATA), .PLL_LOCKED(PLL_LOCKED),
  .PLL_ENABLE(PLL_ENABLE), .TX_OUT(TX_OUT), .CHANNEL(CHANNEL), .OUT_POWER(OUT_POWER), .IRQ(IRQ)
);

// ===== bench/testbench.sv
// Purpose: self-checking bench for the continuous transmission block
// Assumes: register reads answer one cycle later, bytes every 640 cycles
// Notes:   tone runs use uniform frames, the modulated run mixed bytes
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic                 CLK_SYS;
  logic                 RESET;
  ctx_pkg::ctx_bus_type REG_BUS;
  logic [7:0]           REG_RDATA;
  logic                 PLL_LOCKED;
  logic                 PLL_ENABLE;
  ctx_pkg::ctx_tx_type  TX_OUT;
  logic [7:0]           CHANNEL;
  logic [7:0]           OUT_POWER;
  logic                 IRQ;
  int                   bad_count;
  int                   compares;

  ctx_top ctx_top_i (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .REG_BUS(REG_BUS), .REG_RDATA(REG_RDATA), .PLL_LOCKED(PLL_LOCKED),
    .PLL_ENABLE(PLL_ENABLE), .TX_OUT(TX_OUT), .CHANNEL(CHANNEL), .OUT_POWER(OUT_POWER), .IRQ(IRQ)
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLK_SYS);
    REG_BUS <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    REG_BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLK_SYS);
    REG_BUS <= '0;
    #1;
    `CHK(REG_RDATA, e)
  endtask

  task automatic t_reset();
    @(posedge CLK_SYS);
    RESET      <= 1'b1;
    PLL_LOCKED <= 1'b0;
    repeat (20) @(posedge CLK_SYS);
    RESET <= 1'b0;
  endtask

  task automatic t_defaults();
    #1;
    `CHK(CHANNEL, ctx_pkg::CHAN_RESET)
    `CHK({TX_OUT.active, PLL_ENABLE, IRQ}, 3'h0)
    rdc(ctx_pkg::ADR_RADIO_STAT, ctx_pkg::STAT_RADIO_OFF);
    rdc(ctx_pkg::ADR_DEVICE_ID, 8'h00);
    rdc(8'h3F, 8'h00);
  endtask

  // broken unlock order must leave the mode idle
  task automatic t_abort();
    wr(ctx_pkg::ADR_TEST_CTRL, ctx_pkg::UNLOCK_CTRL);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_ID_A);
    wr(ctx_pkg::ADR_DEVICE_ID, 8'h12);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_ID_B);
    rdc(ctx_pkg::ADR_MODE_STAT, 8'h00);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_ID_B);
    rdc(ctx_pkg::ADR_MODE_STAT, 8'h00);
  endtask

  task automatic t_run(input logic tone, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] fb [3];
    logic [7:0] b;
    logic [7:0] len;
    logic       up;
    logic       dn;
    fb = '{b0, b1, b2};
    len = tone ? 8'h03 : 8'h7F;
    wr(ctx_pkg::ADR_RADIO_CTL1, 8'h00);
    wr(ctx_pkg::ADR_STATE_CMD, {3'h0, ctx_pkg::CMD_RADIO_OFF});
    rdc(ctx_pkg::ADR_RADIO_STAT, ctx_pkg::STAT_RADIO_OFF);
    wr(ctx_pkg::ADR_CHAN_SEL, 8'h33);
    wr(ctx_pkg::ADR_OUT_POWER, 8'h05);
    if (tone) begin
      wr(ctx_pkg::ADR_RADIO_CTL2, 8'h03);
      wr(ctx_pkg::ADR_RX_CTL, 8'hA7);
    end
    wr(ctx_pkg::ADR_FB_INDEX, 8'h00);
    wr(ctx_pkg::ADR_FB_DATA, len);
    for (int i = 0; i < len; i++) wr(ctx_pkg::ADR_FB_DATA, fb[i % 3]);
    #1;
    `CHK({CHANNEL, OUT_POWER}, 16'h3305)
    wr(ctx_pkg::ADR_TEST_CTRL, ctx_pkg::UNLOCK_CTRL);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_ID_A);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_ID_B);
    rdc(ctx_pkg::ADR_MODE_STAT, {5'h00, tone, 2'h1});
    wr(ctx_pkg::ADR_STATE_CMD, {3'h0, ctx_pkg::CMD_PLL_ON});
    wr(ctx_pkg::ADR_STATE_CMD, {3'h0, ctx_pkg::CMD_TX_START});
    repeat (3) @(posedge CLK_SYS);
    #1;
    `CHK({TX_OUT.active, PLL_ENABLE}, 2'h1)
    rdc(ctx_pkg::ADR_RADIO_STAT, ctx_pkg::STAT_PLL_ON);
    @(posedge CLK_SYS);
    PLL_LOCKED <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    #1;
    `CHK(IRQ, 1'b0)
    rdc(ctx_pkg::ADR_IRQ_STATUS, 8'h01);
    wr(ctx_pkg::ADR_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge CLK_SYS);
    #1;
    `CHK(IRQ, 1'b1)
    wr(ctx_pkg::ADR_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge CLK_SYS);
    #1;
    `CHK(IRQ, 1'b0)
    wr(ctx_pkg::ADR_STATE_CMD, {3'h0, ctx_pkg::CMD_TX_START});
    for (int k = 0; k < 5; k++) begin
      // first strobe stands in the cycle after the start write is taken
      repeat (k == 0 ? 1 : 640) @(posedge CLK_SYS);
      #1;
      b = fb[k % 3];
      up = tone && (b == 8'hFF);
      dn = tone && (b == 8'h00);
      `CHK(TX_OUT, {2'h3, b, !(up || dn), up, dn})
    end
    // tone frames of three bytes have wrapped by now, the long frame not
    rdc(ctx_pkg::ADR_IRQ_STATUS, tone ? 8'h06 : 8'h02);
    rdc(ctx_pkg::ADR_RADIO_STAT, ctx_pkg::STAT_BUSY_TX);
    wr(ctx_pkg::ADR_DEVICE_ID, ctx_pkg::UNLOCK_LEAVE);
    repeat (2) @(posedge CLK_SYS);
    #1;
    `CHK({TX_OUT.active, TX_OUT.strobe}, 2'h0)
    repeat (700) @(posedge CLK_SYS);
    #1;
    `CHK(TX_OUT.active, 1'b0)
    rdc(ctx_pkg::ADR_RADIO_STAT, ctx_pkg::STAT_RADIO_OFF);
    t_reset();
  endtask

  // hang guard, well beyond the expected run
  initial begin
    #(20000 * 50);
    bad_count++;
    end_of_test();
  end

  initial begin
    RESET      = 1'b1;
    REG_BUS    = '0;
    PLL_LOCKED = 1'b0;
    bad_count  = 0;
    compares   = 0;
    t_reset();
    t_defaults();
    t_abort();
    t_run(1'b1, 8'hFF, 8'hFF, 8'hFF);
    t_run(1'b1, 8'h00, 8'h00, 8'h00);
    t_run(1'b0, 8'h5A, 8'h3C, 8'hC3);
    end_of_test();
  end
endmodule
